// >>> rtl/xcbt_chain.sv
// board-level connectivity chain: mode control, pad steering and chain output
`timescale 1ns/100ps
`include "xcbt_map.svh"

module xcbt_chain
    import xcbt_pkg::*;
#(
    parameter int NUM_BALLS = `XCBT_NUM_BALLS
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 host_reset_n,
    input  wire logic                 lad0_in,
    input  wire logic                 lframe_n_in,
    input  wire logic                 test_pin_in,
    input  wire logic [NUM_BALLS-1:0] ball_in,
    input  wire logic                 core_lad0_out,
    input  wire logic                 core_lad0_oe,
    input  wire logic [NUM_BALLS-1:0] core_ball_out,
    input  wire logic [NUM_BALLS-1:0] core_ball_oe,
    input  wire logic                 core_wake_event,
    input  wire logic                 core_wake_oe,
    output logic                      lad0_out,
    output logic                      lad0_oe,
    output logic [NUM_BALLS-1:0]      ball_out,
    output logic [NUM_BALLS-1:0]      ball_oe,
    output logic [NUM_BALLS-1:0]      core_ball_in,
    output logic                      core_lad0_in,
    output logic                      core_lframe_n_in,
    output logic                      wake_event_out,
    output logic                      wake_event_oe,
    output logic                      test_mode
);

    localparam int CHAIN_W = NUM_BALLS + 3;

    // cascade of two-input xnor gates, first input feeds the first gate directly
    function automatic logic xnor_chain(input logic [CHAIN_W-1:0] v);
        logic acc;
        acc = v[0];
        for (int i = 1; i < CHAIN_W; i++) begin
            acc = ~(acc ^ v[i]);
        end
        return acc;
    endfunction

    xcbt_mode_t              mode_reg;
    xcbt_mode_t              mode_next;
    logic                    hrst_prev_reg;
    logic                    hrst_prev_next;
    logic                    hrst_rise;
    logic                    select_test;
    logic [CHAIN_W-1:0]      chain_vec;
    logic                    chain_out;
    logic                    in_test;

    // edge detect: pins are synchronous, so one stored level suffices
    assign hrst_rise   = host_reset_n & ~hrst_prev_reg;
    assign select_test = ~lad0_in & ~lframe_n_in;

    always_comb begin
        hrst_prev_next = host_reset_n;
        mode_next      = mode_reg;
        // mode chosen by the lpc pins at the host reset rise
        if (hrst_rise) begin
            mode_next = select_test ? XCBT_TEST : XCBT_NORMAL;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_reg      <= xcbt_mode_t'(`XCBT_MODE_RST);
            hrst_prev_reg <= `XCBT_HRST_PREV_RST;
        end else begin
            mode_reg      <= mode_next;
            hrst_prev_reg <= hrst_prev_next;
        end
    end

    assign in_test   = (mode_reg == XCBT_TEST);
    assign test_mode = in_test;

    // chain members: test pin, lpc pins and every general ball
    assign chain_vec = {test_pin_in, lframe_n_in, lad0_in, ball_in};
    // purely combinational so a toggle shows without waiting for a clock
    assign chain_out = xnor_chain(chain_vec);

    always_comb begin
        lad0_out         = core_lad0_out;
        lad0_oe          = core_lad0_oe;
        ball_out         = core_ball_out;
        ball_oe          = core_ball_oe;
        core_ball_in     = ball_in;
        core_lad0_in     = lad0_in;
        core_lframe_n_in = lframe_n_in;
        // normal mode returns the wake pin to the core
        wake_event_out   = core_wake_event;
        wake_event_oe    = core_wake_oe;
        // detach functions, release every pad except the chain output
        if (in_test) begin
            lad0_out         = 1'b0;
            lad0_oe          = 1'b0;
            ball_out         = '0;
            ball_oe          = '0;
            // core sees idle levels so it does not react to tester patterns
            core_ball_in     = '0;
            core_lad0_in     = 1'b1;
            core_lframe_n_in = 1'b1;
            // wake pin driven with the chain result
            wake_event_out   = chain_out;
            wake_event_oe    = 1'b1;
        end
    end

    property p_single_toggle;
        @(posedge clk) disable iff (srst)
        (in_test && $past(in_test) && $countones(chain_vec ^ $past(chain_vec)) == 1)
            |-> (wake_event_out != $past(wake_event_out));
    endproperty
    a_single_toggle: assert property (p_single_toggle)
        else $error("chain output did not follow a single input toggle");

    property p_detach;
        @(posedge clk) disable iff (srst)
        in_test |-> (ball_oe == '0 && !lad0_oe && core_ball_in == '0);
    endproperty
    a_detach: assert property (p_detach)
        else $error("a pad is still driven by the core in test mode");

    property p_wake_drives;
        @(posedge clk) disable iff (srst)
        in_test |-> (wake_event_oe && wake_event_out == xnor_chain(chain_vec));
    endproperty
    a_wake_drives: assert property (p_wake_drives)
        else $error("wake pin is not driving the chain result");

    property p_test_pin;
        @(posedge clk) disable iff (srst)
        (in_test && $past(in_test) && $changed(test_pin_in)
            && $stable(chain_vec[CHAIN_W-2:0]))
            |-> $changed(wake_event_out);
    endproperty
    a_test_pin: assert property (p_test_pin)
        else $error("test pin toggle did not reach the chain output");

    property p_enter;
        @(posedge clk) disable iff (srst)
        (hrst_rise && !lad0_in && !lframe_n_in) |=> in_test;
    endproperty
    a_enter: assert property (p_enter)
        else $error("test mode not entered at host reset rise");

    property p_lpc_member;
        @(posedge clk) disable iff (srst)
        (in_test && $past(in_test) && ($changed(lad0_in) ^ $changed(lframe_n_in))
            && $stable(ball_in) && $stable(test_pin_in))
            |-> $changed(wake_event_out);
    endproperty
    a_lpc_member: assert property (p_lpc_member)
        else $error("lpc pin toggle did not reach the chain output");

    property p_exit;
        @(posedge clk) disable iff (srst)
        (hrst_rise && (lad0_in || lframe_n_in)) |=> !in_test;
    endproperty
    a_exit: assert property (p_exit)
        else $error("test mode not left at host reset rise");

    property p_por;
        @(posedge clk)
        srst |=> (!in_test && !test_mode);
    endproperty
    a_por: assert property (p_por)
        else $error("power-on reset did not leave test mode");

    // the first cycle after leaving test mode hands the pin back to the core, so it may move
    property p_after_exit;
        @(posedge clk) disable iff (srst)
        (!in_test && !$past(in_test) && $stable(core_wake_event) && $stable(core_wake_oe))
            |-> ($stable(wake_event_out) && wake_event_oe == core_wake_oe);
    endproperty
    a_after_exit: assert property (p_after_exit)
        else $error("wake pin moved with chain inputs outside test mode");

    property p_hold;
        @(posedge clk) disable iff (srst)
        !hrst_rise |=> (mode_reg == $past(mode_reg));
    endproperty
    a_hold: assert property (p_hold)
        else $error("mode changed without a host reset rise");

    property p_cov_enter;
        @(posedge clk) disable iff (srst)
        !in_test ##1 in_test;
    endproperty
    c_cov_enter: cover property (p_cov_enter);

    property p_cov_toggle;
        @(posedge clk) disable iff (srst)
        in_test ##1 (in_test && $changed(wake_event_out));
    endproperty
    c_cov_toggle: cover property (p_cov_toggle);

    property p_cov_exit;
        @(posedge clk) disable iff (srst)
        in_test ##1 !in_test;
    endproperty
    c_cov_exit: cover property (p_cov_exit);

endmodule // xcbt_chain

// >>> rtl/xcbt_map.svh
// constants for the board-test chain: reset values and default sizes
`ifndef XCBT_MAP_SVH
`define XCBT_MAP_SVH

// mode after a core-supply power-on reset
`define XCBT_MODE_RST 1'b0
// previous host reset level after power-on; high so no false edge is seen
`define XCBT_HRST_PREV_RST 1'b1
// number of general chain balls besides lad0, lframe_n and the test pin
`define XCBT_NUM_BALLS 48

`endif

// >>> rtl/xcbt_pkg.sv
// types shared by the board-test chain logic
package xcbt_pkg;

    typedef enum logic [0:0] {
        XCBT_NORMAL = 1'b0,
        XCBT_TEST   = 1'b1
    } xcbt_mode_t;

endpackage

// >>> bench/xcbt_tester.sv
// board tester model: drives the chain pins and the host reset pin
`timescale 1ns/100ps
module xcbt_tester #(
    parameter int NB = 8
) (
    input  wire logic     clk,
    output logic          host_reset_n,
    output logic          lad0,
    output logic          lframe_n,
    output logic          test_pin,
    output logic [NB-1:0] balls
);
    initial {host_reset_n, lad0, lframe_n, test_pin, balls} = '0;
    task automatic select(input logic a, input logic f);
        @(posedge clk) #10;
        {host_reset_n, lad0, lframe_n} = {1'b0, a, f};
        @(posedge clk) #10;
        host_reset_n = 1'b1;
        repeat (2) @(posedge clk);
        #10;
    endtask
    task automatic flip(input int i);
        @(posedge clk) #10;
        if (i < NB) balls[i] = ~balls[i];
        else if (i == NB) lad0 = ~lad0;
        else if (i == NB + 1) lframe_n = ~lframe_n;
        else test_pin = ~test_pin;
        #1;
    endtask
endmodule // xcbt_tester

// >>> bench/xcbt_chain_test.sv
// self-checking bench for the board-test chain
`timescale 1ns/100ps
module xcbt_chain_test;
    localparam int NB = 8;
    logic          clk = 1'b0;
    logic          srst = 1'b1;
    logic          cw = 1'b1;
    logic          hr_n, lad0, lfr_n, tpin, lad0_oe, wake, wake_oe, tmode;
    logic          lad0_o, cl0_in, clf_in;
    logic [NB-1:0] balls, ball_oe, ball_o, cb_in;
    logic          p;
    int            failures = 0;
    int            comparisons = 0;
    always #50 clk = ~clk;
    xcbt_tester #(.NB(NB)) tester (.clk(clk), .host_reset_n(hr_n), .lad0(lad0),
        .lframe_n(lfr_n), .test_pin(tpin), .balls(balls));
    xcbt_chain #(.NUM_BALLS(NB)) DUT (.clk(clk), .srst(srst), .host_reset_n(hr_n),
        .lad0_in(lad0), .lframe_n_in(lfr_n), .test_pin_in(tpin), .ball_in(balls),
        .core_lad0_out(1'b1), .core_lad0_oe(1'b1), .core_ball_out(8'h5a),
        .core_ball_oe(8'hc3), .core_wake_event(cw), .core_wake_oe(1'b0),
        .lad0_out(lad0_o), .lad0_oe(lad0_oe), .ball_out(ball_o), .ball_oe(ball_oe),
        .core_ball_in(cb_in), .core_lad0_in(cl0_in), .core_lframe_n_in(clf_in),
        .wake_event_out(wake), .wake_event_oe(wake_oe), .test_mode(tmode));
    task automatic chk(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    // parity of the gate count, one less than the chain length, decides the inversion
    function automatic logic chain_exp();
        return ^{balls, lad0, lfr_n, tpin} ^ 1'((NB + 2) % 2);
    endfunction
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic enter();
        tester.select(1'b0, 1'b0);
        chk("test_mode", 1'b1, tmode);
        chk("lad0_oe", 1'b0, lad0_oe);
        chk("ball_oe_any", 1'b0, |ball_oe);
        chk("lad0_out", 1'b0, lad0_o);
        chk("ball_out_any", 1'b0, |ball_o);
        chk("core_ball_in_any", 1'b0, |cb_in);
        chk("core_lad0_in", 1'b1, cl0_in);
        chk("core_lframe_n_in", 1'b1, clf_in);
        chk("wake_oe", 1'b1, wake_oe);
        chk("wake_chain", chain_exp(), wake);
    endtask
    task automatic t_chain();
        enter();
        for (int i = 0; i < NB + 3; i++) begin
            p = wake;
            tester.flip(i);
            chk("wake_flip", ~p, wake);
            chk("wake_chain", chain_exp(), wake);
        end
        chk("test_mode_held", 1'b1, tmode);
        $display("test chain done");
    endtask
    task automatic t_exit();
        tester.select(1'b0, 1'b1);
        chk("test_mode", 1'b0, tmode);
        cw = 1'b0;
        for (int i = 0; i < NB + 3; i += 3) begin
            tester.flip(i);
            chk("wake_core", cw, wake);
        end
        chk("test_mode_held", 1'b0, tmode);
        chk("ball_oe_core", 1'b1, ball_oe === 8'hc3);
        chk("wake_oe_core", 1'b0, wake_oe);
        chk("lad0_out_core", 1'b1, lad0_o);
        chk("ball_out_core", 1'b1, ball_o === 8'h5a);
        chk("core_ball_in", 1'b1, cb_in === balls);
        chk("core_lad0_in", lad0, cl0_in);
        chk("core_lframe_n_in", lfr_n, clf_in);
        enter();
        tester.select(1'b1, 1'b0);
        chk("test_mode", 1'b0, tmode);
        $display("test exit done");
    endtask
    task automatic t_por();
        enter();
        @(posedge clk) #10;
        srst = 1'b1;
        @(posedge clk) #10;
        srst = 1'b0;
        chk("test_mode", 1'b0, tmode);
        chk("wake_core", cw, wake);
        chk("wake_oe_core", 1'b0, wake_oe);
        $display("test power-on exit done");
    endtask
    initial begin
        #(100 * 400);
        failures++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        #10;
        srst = 1'b0;
        chk("test_mode", 1'b0, tmode);
        t_chain();
        t_exit();
        t_por();
        test_done();
    end
endmodule // xcbt_chain_test
